// *** logic/actuator_status_ctrl.sv ***
// status led, command mode programming, heater and feedback mapping
// ----------------------------------------------------------------
// ----------------------------------------------------------------
`timescale 1ns/1ns
`include "actuator_status_map.svh"

module actuator_status_ctrl #(
   parameter int TICK_CYCLES = `TICK_CYCLES,
   parameter int CMD_W       = 12
) (
   // clock and reset
   input  wire logic                clk,
   input  wire logic                resetn,
   // operating conditions
   input  wire logic                powered,
   input  wire logic                power_going_off,
   input  wire logic                motor_rotating,
   input  wire logic [7:0]          temp_c,
   // anomaly inputs
   input  wire logic                fault_torque,
   input  wire logic                fault_undervolt,
   input  wire logic                fault_op_timeout,
   input  wire logic                fault_driver,
   input  wire logic                fault_pos_timeout,
   // buttons
   input  wire logic                btn_memory,
   input  wire logic                btn_open,
   input  wire logic                btn_close,
   // analog command, digitised
   input  wire logic                cur_present,
   input  wire logic [CMD_W-1:0]    cur_cmd,
   input  wire logic                volt_present,
   input  wire logic [CMD_W-1:0]    volt_cmd,
   // position
   input  wire logic [CMD_W-1:0]    position,
   // outputs
   output logic [1:0]               led_color,
   output logic                     heater_element,
   output logic                     actuator_blocked,
   output logic                     prog_mode,
   output logic                     reverse_mode,
   output logic                     setpoint_valid,
   output logic [CMD_W-1:0]         setpoint,
   output logic [CMD_W-1:0]         fb_volt,
   output logic [CMD_W-1:0]         fb_cur
);

   // ----------------------------------------------------------------
   // timebase
   // ----------------------------------------------------------------
   logic [23:0] pre;
   logic        tick;
   assign tick = (pre == 24'(TICK_CYCLES - 1));

   always_ff @(posedge clk) begin
      if (!resetn || tick) begin
         pre <= 24'h000000;
      end else begin
         pre <= pre + 24'h000001;
      end
   end

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   // counting ticks rather than cycles keeps the hold counters nine bits wide
   // true when a count of ticks reaches lim on the current tick
   function automatic logic last_tick(input logic [8:0] cnt, input logic [8:0] lim);
      return cnt == lim - 9'h001;
   endfunction

   // phase length in ticks for the active mode and motor state
   function automatic logic [3:0] pick_len(input logic rev, input logic rot,
                                           input logic [3:0] s_idle, input logic [3:0] s_work,
                                           input logic [3:0] r_idle, input logic [3:0] r_work);
      return rev ? (rot ? r_work : r_idle) : (rot ? s_work : s_idle);
   endfunction

   // lowest code wins when several faults are present
   function automatic logic [2:0] flash_count(input logic [4:0] f);
      logic [2:0] n;
      n = `ERR_POSTIMEOUT_N;
      if (f[3])
         n = `ERR_DRIVER_N;
      if (f[2])
         n = `ERR_OPTIMEOUT_N;
      if (f[1])
         n = `ERR_UNDERVOLT_N;
      if (f[0])
         n = `ERR_TORQUE_N;
      return n;
   endfunction

   // ----------------------------------------------------------------
   // anomaly selection and blocking
   // ----------------------------------------------------------------
   wire       any_fault = fault_torque | fault_undervolt | fault_op_timeout
                        | fault_driver | fault_pos_timeout;
   wire [2:0] fault_n = flash_count({fault_pos_timeout, fault_driver, fault_op_timeout,
                                     fault_undervolt, fault_torque});

   wire block_event = fault_torque | fault_op_timeout | fault_driver | fault_pos_timeout;

   // latched until reset: blocking faults need a power cycle
   always_ff @(posedge clk) begin
      if (!resetn) begin
         actuator_blocked <= 1'b0;
      end else if (block_event) begin
         actuator_blocked <= 1'b1;
      end
   end

   wire halted = actuator_blocked | fault_undervolt;

   // ----------------------------------------------------------------
   // programming sequence
   // ----------------------------------------------------------------
   actuator_status_pkg::prog_state_t st;
   actuator_status_pkg::prog_state_t next_st;
   logic [8:0] hold;
   logic [8:0] idle;
   logic       ack;

   wire both_oc  = btn_open & btn_close;
   wire any_btn  = btn_memory | btn_open | btn_close;
   wire in_prog  = (st == actuator_status_pkg::PRG_ARMED)
                 || (st == actuator_status_pkg::PRG_WAIT);
   wire hold_on  = btn_memory | (in_prog & both_oc);
   wire idle_out = tick && last_tick(idle, `PROG_IDLE_TICKS);
   wire hold_clr = !hold_on || (next_st != st);

   always_comb begin
      next_st = st;
      case (st)
         actuator_status_pkg::PRG_RUN: begin
            if (btn_memory && tick && last_tick(hold, `PROG_ENTER_TICKS))
               next_st = actuator_status_pkg::PRG_ENTER;
         end
         actuator_status_pkg::PRG_ENTER: begin
            // wait for release so the same press cannot also exit
            if (!btn_memory)
               next_st = actuator_status_pkg::PRG_ARMED;
         end
         actuator_status_pkg::PRG_ARMED: begin
            if (btn_memory && tick && last_tick(hold, `PROG_EXIT_TICKS))
               next_st = actuator_status_pkg::PRG_WAIT;
            else if (idle_out)
               next_st = actuator_status_pkg::PRG_RUN;
         end
         actuator_status_pkg::PRG_WAIT: begin
            if (!btn_memory)
               next_st = actuator_status_pkg::PRG_RUN;
         end
         default: next_st = actuator_status_pkg::PRG_RUN;
      endcase
   end

   wire swap = (st == actuator_status_pkg::PRG_ARMED) && both_oc && !btn_memory && tick
             && last_tick(hold, `MODE_SWAP_TICKS);

   always_ff @(posedge clk) begin
      if (!resetn) begin
         st <= actuator_status_pkg::PRG_RUN;
      end else begin
         st <= next_st;
      end
   end

   // saturating, so a stuck button cannot wrap into a second event
   always_ff @(posedge clk) begin
      if (!resetn || hold_clr) begin
         hold <= 9'h000;
      end else if (tick && hold != 9'h1FF) begin
         hold <= hold + 9'h001;
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn || any_btn || !in_prog) begin
         idle <= 9'h000;
      end else if (tick) begin
         idle <= idle + 9'h001;
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         reverse_mode <= 1'b0;
      end else if (swap) begin
         reverse_mode <= ~reverse_mode;
      end
   end

   // acknowledge stays lit until open or close is let go
   always_ff @(posedge clk) begin
      if (!resetn) begin
         ack <= 1'b0;
      end else if (swap) begin
         ack <= 1'b1;
      end else if (!both_oc) begin
         ack <= 1'b0;
      end
   end

   assign prog_mode = (st != actuator_status_pkg::PRG_RUN);

   // ----------------------------------------------------------------
   // blink pattern
   // ----------------------------------------------------------------
   logic [3:0] ph;
   logic       lit;
   logic [2:0] flashes;
   logic       grp_gap;

   wire [3:0] on_t  = pick_len(reverse_mode, motor_rotating, `STD_IDLE_ON, `STD_WORK_ON,
                               `REV_IDLE_ON, `REV_WORK_ON);
   wire [3:0] off_t = pick_len(reverse_mode, motor_rotating, `STD_IDLE_OFF, `STD_WORK_OFF,
                               `REV_IDLE_OFF, `REV_WORK_OFF);
   wire [3:0] err_off = (flashes == fault_n - 3'h1) ? `ERR_GROUP_GAP : `ERR_FLASH_GAP;
   wire [3:0] cur_on  = any_fault ? `ERR_FLASH_ON : on_t;
   wire [3:0] cur_off = any_fault ? err_off : off_t;
   wire       ph_end  = tick && (ph >= (lit ? cur_on : cur_off) - 4'h1);

   // phase lengths follow state changes within the current phase, from the next tick on
   always_ff @(posedge clk) begin
      if (!resetn) begin
         ph      <= 4'h0;
         lit     <= 1'b1;
         flashes <= 3'h0;
         grp_gap <= 1'b0;
      end else if (any_fault != grp_gap) begin
         ph      <= 4'h0;
         lit     <= 1'b1;
         flashes <= 3'h0;
         grp_gap <= any_fault;
      end else if (ph_end) begin
         ph  <= 4'h0;
         lit <= ~lit;
         if (!lit)
            flashes <= 3'h0;
         if (!lit && flashes != fault_n - 3'h1)
            flashes <= flashes + 3'h1;
      end else if (tick) begin
         ph <= ph + 4'h1;
      end
   end

   actuator_status_pkg::led_color_t next_color;
   assign next_color =
      !powered   ? actuator_status_pkg::LED_OFF :
      any_fault  ? (lit ? actuator_status_pkg::LED_RED
                        : actuator_status_pkg::LED_OFF) :
      (prog_mode || ack) ? actuator_status_pkg::LED_YELLOW :
      !lit       ? actuator_status_pkg::LED_OFF :
      power_going_off ? actuator_status_pkg::LED_YELLOW
                      : actuator_status_pkg::LED_GREEN;

   // ----------------------------------------------------------------
   // command and feedback
   // ----------------------------------------------------------------
   // current input wins only when present; both present is not allowed
   wire [CMD_W-1:0] raw_cmd = cur_present ? cur_cmd : volt_cmd;
   wire             raw_ok  = cur_present | volt_present;
   // position code 0 is closed, full scale is open
   wire [CMD_W-1:0] map_cmd = reverse_mode ? ~raw_cmd : raw_cmd;
   wire             heat_ok = powered && !motor_rotating && (temp_c <= `HEAT_LIMIT_C);


   // ----------------------------------------------------------------
   // output registers
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!resetn) begin
         led_color <= actuator_status_pkg::LED_OFF;
      end else begin
         led_color <= next_color;
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         heater_element <= 1'b0;
      end else begin
         heater_element <= heat_ok;
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         setpoint_valid <= 1'b0;
      end else begin
         setpoint_valid <= raw_ok && !prog_mode && !halted;
      end
   end

   // holds the last accepted command during programming; it keeps following while halted
   always_ff @(posedge clk) begin
      if (!resetn) begin
         setpoint <= '0;
      end else if (raw_ok && !prog_mode) begin
         setpoint <= map_cmd;
      end
   end

   // feedback ignores the command mode on purpose
   always_ff @(posedge clk) begin
      if (!resetn) begin
         fb_volt <= '0;
      end else begin
         fb_volt <= position;
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         fb_cur <= '0;
      end else begin
         fb_cur <= position;
      end
   end

endmodule

// *** logic/actuator_status_map.svh ***
// timing constants and code maps for the actuator status and mode control
`ifndef ACTUATOR_STATUS_MAP_SVH
`define ACTUATOR_STATUS_MAP_SVH
`define CLK_HZ            25000000
`define TICK_MS           100
`define TICK_CYCLES       ((`CLK_HZ / 1000) * `TICK_MS)
`define STD_IDLE_ON       4'h1
`define STD_IDLE_OFF      4'h9
`define STD_WORK_ON       4'h6
`define STD_WORK_OFF      4'h4
`define REV_IDLE_ON       4'h1
`define REV_IDLE_OFF      4'h4
`define REV_WORK_ON       4'h3
`define REV_WORK_OFF      4'h2
`define ERR_FLASH_ON      4'h1
`define ERR_FLASH_GAP     4'h3
`define ERR_GROUP_GAP     4'hA
`define ERR_TORQUE_N      3'h1
`define ERR_UNDERVOLT_N   3'h3
`define ERR_OPTIMEOUT_N   3'h4
`define ERR_DRIVER_N      3'h5
`define ERR_POSTIMEOUT_N  3'h6
`define PROG_ENTER_TICKS  9'h032
`define MODE_SWAP_TICKS   9'h015
`define PROG_EXIT_TICKS   9'h033
`define PROG_IDLE_TICKS   9'h12C
`define HEAT_LIMIT_C      8'h19
`define CMD_FULL          12'hFFF
`endif

// *** logic/actuator_status_pkg.sv ***
// types for the actuator status and mode control
package actuator_status_pkg;
   typedef enum logic [1:0] {
      LED_OFF    = 2'b00,
      LED_GREEN  = 2'b01,
      LED_YELLOW = 2'b10,
      LED_RED    = 2'b11
   } led_color_t;
   typedef enum logic [1:0] {
      PRG_RUN   = 2'b00,
      PRG_ENTER = 2'b01,
      PRG_ARMED = 2'b10,
      PRG_WAIT  = 2'b11
   } prog_state_t;
endpackage

// *** verif/actuator_status_ctrl_sva.sv ***
// concurrent checks on the status and mode control ports
`timescale 1ns/1ns
module actuator_status_ctrl_sva #(parameter int TICK_CYCLES = 10, parameter int CMD_W = 12) (
   // watched ports
   input wire logic clk, resetn, powered, motor_rotating, cur_present,
   input wire logic fault_torque, fault_undervolt, fault_op_timeout, fault_driver,
   input wire logic fault_pos_timeout, heater_element, actuator_blocked, prog_mode,
   input wire logic reverse_mode, setpoint_valid,
   input wire logic [7:0] temp_c,
   input wire logic [1:0] led_color,
   input wire logic [CMD_W-1:0] cur_cmd, volt_cmd, position, setpoint, fb_volt, fb_cur
);
   // ---------
   // properties
   // ---------
   wire blk = fault_torque | fault_op_timeout | fault_driver | fault_pos_timeout;
   wire quiet = !blk && !fault_undervolt && !actuator_blocked && powered;
   wire [CMD_W-1:0] cmd = cur_present ? cur_cmd : volt_cmd;
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   sequence in_prog;
      prog_mode [*2];
   endsequence
   heater_cond_a:
      assert property ($past(resetn) |-> heater_element ==
         $past(powered && !motor_rotating && temp_c <= 8'h19)) else $error("heater wrong");
   feedback_copy_a:
      assert property ($past(resetn) |-> fb_volt == $past(position) && fb_cur == $past(position))
         else $error("feedback wrong");
   std_map_a:
      assert property ($past(resetn) && setpoint_valid && !$past(reverse_mode) |->
         setpoint == $past(cmd)) else $error("standard setpoint wrong");
   rev_map_a:
      assert property ($past(resetn) && setpoint_valid && $past(reverse_mode) |->
         setpoint == ~$past(cmd)) else $error("reverse setpoint wrong");
   prog_ignore_a:
      assert property (in_prog |-> !setpoint_valid && $stable(setpoint))
         else $error("command followed in programming");
   prog_yellow_a:
      assert property (in_prog and quiet [*2] |-> led_color == 2'b10) else $error("no yellow");
   red_wins_a:
      assert property (((blk || fault_undervolt) && powered) [*2] |->
         led_color inside {2'b11, 2'b00}) else $error("anomaly not shown");
   block_hold_a:
      assert property (blk || actuator_blocked |=> actuator_blocked) else $error("block lost");
   undervolt_soft_a:
      assert property (fault_undervolt && !blk && !actuator_blocked |=>
         !setpoint_valid && !actuator_blocked) else $error("undervoltage handling wrong");
   swap_in_prog_a:
      assert property ($past(resetn) && $changed(reverse_mode) |-> $past(prog_mode))
         else $error("mode swapped outside programming");
   reset_mode_a:
      assert property (disable iff (1'b0) !resetn |=> !reverse_mode && !prog_mode)
         else $error("reset mode wrong");
endmodule
bind actuator_status_ctrl actuator_status_ctrl_sva #(.TICK_CYCLES(TICK_CYCLES), .CMD_W(CMD_W)) sva_u (
   .clk, .resetn, .powered, .motor_rotating, .cur_present, .fault_torque, .fault_undervolt,
   .fault_op_timeout, .fault_driver, .fault_pos_timeout, .heater_element, .actuator_blocked,
   .prog_mode, .reverse_mode, .setpoint_valid, .temp_c, .led_color, .cur_cmd, .volt_cmd,
   .position, .setpoint, .fb_volt, .fb_cur);

// *** verif/command_source_model.sv ***
// external controller model driving one analog command input at a time
`timescale 1ns/1ns
module command_source_model #(parameter int W = 12) (
   // choice of input and level
   input  wire logic         clk,
   input  wire logic [1:0]   src,
   input  wire logic [W-1:0] level,
   // command inputs of the block
   output logic              cur_present,
   output logic [W-1:0]      cur_cmd,
   output logic              volt_present,
   output logic [W-1:0]      volt_cmd
);
   logic [W-1:0] junk = '0;
   // an unplugged input floats, so it never holds a clean value
   always @(posedge clk) junk <= {junk[W-2:0], ~junk[W-1]};
   assign cur_present  = src == 2'h1;
   assign volt_present = src == 2'h2;
   assign cur_cmd      = cur_present ? level : junk;
   assign volt_cmd     = volt_present ? level : junk;
endmodule

// *** verif/actuator_status_ctrl_tb_top.sv ***
// testbench for the actuator status and mode control
`timescale 1ns/1ns
module actuator_status_ctrl_tb_top;
   logic clk = 1'b0, resetn = 1'b0, powered = 1'b1, power_going_off = 1'b0, motor_rotating = 1'b0;
   logic btn_memory = 1'b0, btn_open = 1'b0, btn_close = 1'b0;
   logic [7:0] temp_c = 8'h14;
   logic [4:0] faults = 5'h00;
   logic [1:0] src = 2'h1, led_color;
   logic [11:0] level = 12'h0AB, position = 12'h000, cur_cmd, volt_cmd, setpoint, fb_volt, fb_cur;
   logic cur_present, volt_present, heater_element, actuator_blocked, prog_mode, reverse_mode;
   logic setpoint_valid;
   logic [9:0] hv [3] = '{10'h219, 10'h01A, 10'h110};
   int fail_count = 0, num_checks = 0, n;
   always #20 clk = ~clk;
   command_source_model #(.W(12)) src_u (.clk, .src, .level, .cur_present, .cur_cmd,
      .volt_present, .volt_cmd);
   actuator_status_ctrl #(.TICK_CYCLES(10), .CMD_W(12)) dut_u (.clk, .resetn, .powered,
      .power_going_off, .motor_rotating, .temp_c, .fault_torque(faults[0]),
      .fault_undervolt(faults[1]), .fault_op_timeout(faults[2]), .fault_driver(faults[3]),
      .fault_pos_timeout(faults[4]), .btn_memory, .btn_open, .btn_close, .cur_present, .cur_cmd,
      .volt_present, .volt_cmd, .position, .led_color, .heater_element, .actuator_blocked,
      .prog_mode, .reverse_mode, .setpoint_valid, .setpoint, .fb_volt, .fb_cur);
   // --------------
   // helper tasks
   // --------------
   task automatic check(input string what, input logic [15:0] seen, exp);
      num_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic bound(input int i, k);
      if (i >= k) begin
         fail_count++;
         print_verdict();
      end
   endtask
   task automatic rst;
      @(posedge clk) resetn <= 1'b0;
      repeat (10) @(posedge clk);
      resetn <= 1'b1;
      @(negedge clk);
   endtask
   // hold times are in cycles, one tick is ten cycles here
   task automatic press(input logic m, oc, input int k);
      @(posedge clk);
      btn_memory <= m;
      btn_open <= oc;
      btn_close <= oc;
      repeat (k) @(posedge clk);
      {btn_memory, btn_open, btn_close} <= 3'h0;
      repeat (20) @(negedge clk);
   endtask
   // skip a partial lit phase, then time one whole dark and lit phase
   task automatic blink(input logic [1:0] c, input int on_t, off_t);
      int i, a, b;
      a = 0;
      b = 0;
      for (i = 0; i < 2000 && led_color !== c; i++) @(negedge clk);
      for (i = 0; i < 2000 && led_color === c; i++) @(negedge clk);
      for (i = 0; i < 2000 && led_color !== c; i++) begin @(negedge clk); b++; end
      for (i = 0; i < 2000 && led_color === c; i++) begin @(negedge clk); a++; end
      bound(i, 2000);
      check("lit", a, on_t);
      check("dark", b, off_t);
   endtask
   task automatic red_group(output int k);
      int i, off, on;
      bit go;
      k = 0;
      off = 0;
      on = 0;
      go = 0;
      for (i = 0; i < 2000; i++) begin
         @(negedge clk);
         if (led_color === 2'b11) begin
            if (off >= 100 && go) begin
               check("group pause", off, 100);
               return;
            end
            if (off >= 100) go = 1;
            else if (go && off > 0) check("flash pause", off, 30);
            if (go && off > 0) k++;
            off = 0;
            on++;
         end else begin
            if (go && on > 0) check("flash", on, 10);
            on = 0;
            off++;
         end
      end
      bound(i, 2000);
   endtask
   // --------------
   // main sequence
   // --------------
   initial begin
      rst();
      @(negedge clk);
      check("reverse", reverse_mode, 1'b0);
      foreach (hv[i]) begin
         @(posedge clk) {motor_rotating, temp_c} <= hv[i][8:0];
         repeat (2) @(negedge clk);
         check("heater", heater_element, hv[i][9]);
      end
      @(posedge clk) {motor_rotating, position} <= {1'b0, 12'h123};
      repeat (2) @(negedge clk);
      check("fb volt", fb_volt, 12'h123);
      check("fb cur", fb_cur, 12'h123);
      check("setpoint", setpoint, 12'h0AB);
      @(posedge clk) {src, level} <= {2'h2, 12'h0CD};
      repeat (3) @(negedge clk);
      check("setpoint", setpoint, 12'h0CD);
      blink(2'b01, 10, 90);
      @(posedge clk) motor_rotating <= 1'b1;
      blink(2'b01, 60, 40);
      @(posedge clk) power_going_off <= 1'b1;
      blink(2'b10, 60, 40);
      @(posedge clk) {power_going_off, motor_rotating} <= 2'b00;
      press(1'b1, 1'b0, 550);
      check("prog", prog_mode, 1'b1);
      check("yellow", led_color, 2'b10);
      @(posedge clk) level <= 12'h111;
      repeat (3) @(negedge clk);
      check("held", setpoint, 12'h0CD);
      press(1'b0, 1'b1, 250);
      check("swap", reverse_mode, 1'b1);
      press(1'b1, 1'b0, 600);
      check("prog", prog_mode, 1'b0);
      check("reverse map", setpoint, 12'hEEE);
      blink(2'b01, 10, 40);
      @(posedge clk) motor_rotating <= 1'b1;
      blink(2'b01, 30, 20);
      @(posedge clk) motor_rotating <= 1'b0;
      press(1'b1, 1'b0, 550);
      for (n = 0; n < 4000 && prog_mode === 1'b1; n++) @(negedge clk);
      check("idle exit", n >= 2950 && n <= 3000, 1'b1);
      for (int i = 0; i < 5; i++) begin
         rst();
         @(posedge clk) faults <= 5'h01 << i;
         red_group(n);
         check("flashes", n, i == 0 ? 1 : i + 2);
         check("blocked", actuator_blocked, i != 1);
         @(posedge clk) faults <= 5'h00;
         repeat (3) @(negedge clk);
         check("re-enable", setpoint_valid, i == 1);
      end
      print_verdict();
   end
endmodule
